// >>> src/fcc_pkg.sv
// Package of constants and types for the feeder close/open control block
package fcc_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 10000000; // System clock rate
	localparam int TICK_US = 1000; // Supervision tick period, microseconds
	localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US; // Cycles a tick
	localparam int FEEDBACK_MS = 250; // Feedback window, milliseconds
	localparam int FEEDBACK_TICKS = (FEEDBACK_MS * 1000) / TICK_US;
	localparam int DEBOUNCE_US = 10000; // Contact debounce time
	localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000000) * DEBOUNCE_US;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_ILK = 10; // Configurable interlock inputs
	localparam int ILK_SEL_W = 4; // Width of an interlock selector
	localparam int NUM_SW = 17; // Debounced switch bundle width

	// Switch bundle bit positions
	localparam int SW_OPEN = 0; // Open permissive input
	localparam int SW_CLOSE = 1; // Momentary local close input
	localparam int SW_CLOSE_B = 2; // Second local close input
	localparam int SW_STOP = 3; // Local open pushbutton, closed at rest
	localparam int SW_HAND = 4; // Selector hand contact
	localparam int SW_AUTO = 5; // Selector auto contact
	localparam int SW_AUTO_STOP = 6; // Auto stop contact, closed at rest
	localparam int SW_ILK0 = 7; // First of ten interlock inputs

	// ----------------------------------------------------------------
	// Control schemes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		FCC_TWO_WIRE = 3'h0, // Plain two-wire control
		FCC_HOA_2H2A = 3'h1, // Hand/off/auto, 2-wire hand, 2-wire auto
		FCC_HOA_3H2A = 3'h2, // Hand/off/auto, 3-wire hand, 2-wire auto
		FCC_HOA_3H3A = 3'h3, // Hand/off/auto, 3-wire both
		FCC_HA_3H2A = 3'h4 // Hand/auto, 3-wire hand, 2-wire auto
	} fcc_scheme_e;

	// Supervision states, one-hot
	typedef enum logic [3:0] {
		FCC_SV_OPEN = 4'h1, // Relay off, feedback gone or window expired
		FCC_SV_CLOSING = 4'h2, // Relay on, waiting for feedback
		FCC_SV_CLOSED = 4'h4, // Relay on, feedback seen or window expired
		FCC_SV_OPENING = 4'h8 // Relay off, waiting for feedback to fall
	} fcc_sv_e;

endpackage : fcc_pkg

// >>> src/fcc_debounce.sv
// Synchroniser and debouncer for a bundle of switch contacts
`timescale 1ns/10ps
module fcc_debounce import fcc_pkg::*; #(
	parameter int WIDTH = NUM_SW,
	parameter int STABLE_CYCLES = DEBOUNCE_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Raw contacts and clean levels
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] clean,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);

	localparam int CW = $clog2(STABLE_CYCLES + 1);

	initial begin
		if (STABLE_CYCLES < 1 || WIDTH < 1)
			$error("fcc_debounce: bad parameters");
	end

	// ----------------------------------------------------------------
	// Per-contact filter
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic s1_reg; // First sync stage, read only by s2
			logic s2_reg; // Second sync stage
			logic [CW-1:0] cnt_reg; // Stability counter

			// Two-stage synchroniser keeps metastability out of the filter
			always_ff @(posedge mclk) begin
				if (!reset_n) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
				end else begin
					s1_reg <= raw[g];
					s2_reg <= s1_reg;
				end
			end

			// Level must hold for the full time before it is accepted
			always_ff @(posedge mclk) begin
				if (!reset_n) begin
					cnt_reg <= '0;
					clean[g] <= 1'b0;
					rise[g] <= 1'b0;
					fall[g] <= 1'b0;
				end else begin
					rise[g] <= 1'b0;
					fall[g] <= 1'b0;
					if (s2_reg == clean[g]) begin
						cnt_reg <= '0; // Stable, nothing to do
					end else if (cnt_reg == CW'(STABLE_CYCLES - 1)) begin
						cnt_reg <= '0;
						clean[g] <= s2_reg;
						rise[g] <= s2_reg; // Edge-based press detection
						fall[g] <= ~s2_reg;
					end else begin
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
			end
		end
	endgenerate

endmodule : fcc_debounce

// >>> src/fcc_supervise.sv
// Contactor feedback supervision: open circuit and welded contactor alarms
`timescale 1ns/10ps
module fcc_supervise import fcc_pkg::*; #(
	parameter int TICK_DIV = TICK_CYCLES,
	parameter int WINDOW_TICKS = FEEDBACK_TICKS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Relay command and contactor feedback
	input wire logic relay_on,
	input wire logic feedback,
	// Alarms, one-cycle pulses
	output logic open_circuit_pulse,
	output logic welded_pulse
);

	localparam int DW = $clog2(TICK_DIV + 1);
	localparam int TW = $clog2(WINDOW_TICKS + 1);

	initial begin
		if (TICK_DIV < 1 || WINDOW_TICKS < 1)
			$error("fcc_supervise: bad parameters");
	end

	logic [DW-1:0] div_reg; // Prescaler
	logic tick; // One-cycle tick enable
	logic [TW-1:0] win_reg; // Window tick count
	logic relay_d_reg; // Previous relay state
	fcc_sv_e st_reg; // Supervision state

	// ----------------------------------------------------------------
	// Prescaled tick, restarted with the window
	// ----------------------------------------------------------------
	assign tick = (div_reg == DW'(TICK_DIV - 1));

	always_ff @(posedge mclk) begin
		if (!reset_n || relay_on != relay_d_reg)
			div_reg <= '0;
		else if (tick)
			div_reg <= '0;
		else
			div_reg <= div_reg + 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (!reset_n)
			relay_d_reg <= 1'b0;
		else
			relay_d_reg <= relay_on;
	end

	// ----------------------------------------------------------------
	// Window counter and state
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			st_reg <= FCC_SV_OPEN;
			win_reg <= '0;
			open_circuit_pulse <= 1'b0;
			welded_pulse <= 1'b0;
		end else begin
			open_circuit_pulse <= 1'b0;
			welded_pulse <= 1'b0;
			if (relay_on && !relay_d_reg) begin
				st_reg <= FCC_SV_CLOSING;
				win_reg <= '0;
			end else if (!relay_on && relay_d_reg) begin
				st_reg <= FCC_SV_OPENING;
				win_reg <= '0;
			end else begin
				case (st_reg)
					FCC_SV_CLOSING: begin
						if (feedback)
							st_reg <= FCC_SV_CLOSED;
						else if (tick && win_reg == TW'(WINDOW_TICKS - 1)) begin
							open_circuit_pulse <= 1'b1;
							st_reg <= FCC_SV_CLOSED;
						end else if (tick)
							win_reg <= win_reg + 1'b1;
					end
					FCC_SV_OPENING: begin
						if (!feedback)
							st_reg <= FCC_SV_OPEN;
						else if (tick && win_reg == TW'(WINDOW_TICKS - 1)) begin
							welded_pulse <= 1'b1;
							st_reg <= FCC_SV_OPEN;
						end else if (tick)
							win_reg <= win_reg + 1'b1;
					end
					FCC_SV_CLOSED: st_reg <= FCC_SV_CLOSED;
					FCC_SV_OPEN: st_reg <= FCC_SV_OPEN;
					default: st_reg <= FCC_SV_OPEN;
				endcase
			end
		end
	end

endmodule : fcc_supervise

// >>> src/fcc_control.sv
// Feeder close/open control: schemes, latched trips and relay drive
//
// Contract
// - Two-wire: closed while close input held
// - Latched faceplate open: open, block until reset
// - Open permissive low: refuse close, unavailable
// - No feedback in 0.25 s: alarm, drop
// - Two-wire hand: hand position closes immediately
// - Off position opens in every hand/off/auto scheme
// - Reset after latched trip recloses if maintained
// - Three-wire hand: pulse close, pulse open
// - 3H/2A auto ignores local open pushbutton
// - Three-wire auto: pulse close, pulse open
// - 3H/3A: open pushbutton works in auto
// - Two-wire auto follows maintained auto contact
// - Hand/auto hand: local open latches trip
// - Auto permissive blocks all other closes
// - Hand/auto: local open active in auto
// - Functions assignable to any of ten interlocks
// - Feedback after 0.25 s off: welded alarm
`timescale 1ns/10ps
module fcc_control import fcc_pkg::*; #(
	parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
	parameter int TICK_DIV = TICK_CYCLES,
	parameter int WINDOW_TICKS = FEEDBACK_TICKS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Configuration
	input wire logic [2:0] scheme,
	input wire logic faceplate_open_latched,
	input wire logic process_open_latched,
	input wire logic [ILK_SEL_W-1:0] sel_two_wire,
	input wire logic [ILK_SEL_W-1:0] sel_auto_perm,
	input wire logic [ILK_SEL_W-1:0] sel_auto_close,
	// Raw switch inputs
	input wire logic open_perm_in,
	input wire logic close_in,
	input wire logic close_b_in,
	input wire logic stop_pb_in,
	input wire logic hand_in,
	input wire logic auto_in,
	input wire logic auto_stop_in,
	input wire logic [NUM_ILK-1:0] interlock_in,
	input wire logic contactor_fb_in,
	// Faceplate keys and serial commands, one-cycle pulses
	input wire logic key_open,
	input wire logic key_close,
	input wire logic key_reset,
	input wire logic serial_open,
	input wire logic serial_close,
	input wire logic process_open,
	// Outputs
	output logic relay_a,
	output logic unavailable,
	output logic tripped,
	output logic open_circuit_alarm,
	output logic welded_alarm
);

	initial begin
		if (NUM_ILK > (1 << ILK_SEL_W) - 1)
			$error("fcc_control: selector too narrow");
		if (NUM_SW != SW_ILK0 + NUM_ILK)
			$error("fcc_control: switch bundle width");
	end

	// ----------------------------------------------------------------
	// Input conditioning
	// ----------------------------------------------------------------
	logic [NUM_SW-1:0] raw; // Raw contact bundle
	logic [NUM_SW-1:0] lvl; // Debounced levels
	logic [NUM_SW-1:0] rise; // Debounced closures
	logic [NUM_SW-1:0] fall; // Debounced openings
	logic fb_s1_reg; // Feedback sync, first stage
	logic fb_reg; // Feedback sync, second stage

	assign raw = {interlock_in, auto_stop_in, auto_in, hand_in, stop_pb_in,
		close_b_in, close_in, open_perm_in};

	// Contacts debounced, presses taken as edges
	fcc_debounce #(.WIDTH(NUM_SW), .STABLE_CYCLES(DEB_CYCLES)) u_deb (
		.mclk(mclk),
		.reset_n(reset_n),
		.raw(raw),
		.clean(lvl),
		.rise(rise),
		.fall(fall)
	);

	// Feedback is only synchronised; the window tolerates bounce
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			fb_s1_reg <= 1'b0;
			fb_reg <= 1'b0;
		end else begin
			fb_s1_reg <= contactor_fb_in;
			fb_reg <= fb_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// Interlock function assignment
	// ----------------------------------------------------------------
	logic [NUM_ILK-1:0] ilk; // Debounced interlock levels
	logic [NUM_ILK-1:0] ilk_rise; // Interlock closures
	logic two_wire_lvl; // Maintained PLC close
	logic auto_perm; // Auto permissive
	logic auto_close_pulse; // Auto close contact pulsed closed

	assign ilk = lvl[SW_ILK0 +: NUM_ILK];
	assign ilk_rise = rise[SW_ILK0 +: NUM_ILK];

	// Selector value 0 means unassigned, 1..10 picks an interlock
	always_comb begin
		two_wire_lvl = 1'b0;
		auto_perm = 1'b0;
		auto_close_pulse = 1'b0;
		for (int i = 0; i < NUM_ILK; i++) begin
			if (sel_two_wire == ILK_SEL_W'(i + 1))
				two_wire_lvl = ilk[i];
			if (sel_auto_perm == ILK_SEL_W'(i + 1))
				auto_perm = ilk[i];
			if (sel_auto_close == ILK_SEL_W'(i + 1))
				auto_close_pulse = ilk_rise[i];
		end
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	logic hand; // Selector in hand
	logic auto_pos; // Selector in auto
	logic off_pos; // Selector in off
	logic is_two; // Plain two-wire
	logic is_hoa; // Any hand/off/auto scheme
	logic is_ha; // Hand/auto scheme
	logic ha_auto; // Hand/auto running in auto
	logic stop_press; // Local open pushbutton pressed

	assign hand = lvl[SW_HAND];
	assign auto_pos = lvl[SW_AUTO];
	assign off_pos = !hand && !auto_pos;
	assign is_two = (scheme == FCC_TWO_WIRE);
	assign is_ha = (scheme == FCC_HA_3H2A);
	assign is_hoa = (scheme == FCC_HOA_2H2A) || (scheme == FCC_HOA_3H2A)
		|| (scheme == FCC_HOA_3H3A);
	assign ha_auto = is_ha && auto_perm;
	// Pushbutton is closed at rest, so a press is its opening
	assign stop_press = fall[SW_STOP];

	// ----------------------------------------------------------------
	// Latched trip
	// ----------------------------------------------------------------
	logic trip_set; // Event that latches a trip
	logic trip_reg; // Latched trip

	always_comb begin
		trip_set = 1'b0;
		if (key_open && faceplate_open_latched)
			trip_set = 1'b1;
		if (process_open && process_open_latched)
			trip_set = 1'b1;
		// Local open latches in both modes; a maintained auto contact
		// would otherwise reclose the feeder on the very next cycle
		if (is_ha && stop_press)
			trip_set = 1'b1;
	end

	// Set wins over a reset arriving in the same cycle
	always_ff @(posedge mclk) begin
		if (!reset_n)
			trip_reg <= 1'b0;
		else if (trip_set)
			trip_reg <= 1'b1;
		else if (key_reset)
			trip_reg <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Close and open requests
	// ----------------------------------------------------------------
	logic maintained; // Maintained close demand
	logic is_maint; // Scheme position driven by a maintained level
	logic close_pulse; // Momentary close request
	logic open_pulse; // Momentary open request
	logic permit; // Closing allowed
	logic alarm_drop; // Open circuit alarm forces open

	always_comb begin
		maintained = 1'b0;
		is_maint = 1'b0;
		close_pulse = 1'b0;
		open_pulse = key_open || serial_open || process_open;
		case (fcc_scheme_e'(scheme))
			FCC_TWO_WIRE: begin
				is_maint = 1'b1;
				maintained = two_wire_lvl;
			end
			FCC_HOA_2H2A: begin
				is_maint = 1'b1;
				// Hand contact drives the maintained input
				maintained = hand || (auto_pos && two_wire_lvl);
			end
			FCC_HOA_3H2A: begin
				if (auto_pos) begin
					is_maint = 1'b1;
					maintained = two_wire_lvl;
				end else if (hand) begin
					close_pulse = rise[SW_CLOSE] || rise[SW_CLOSE_B]
						|| key_close || serial_close;
					open_pulse = open_pulse || stop_press;
				end
				// Local open ignored in auto
			end
			FCC_HOA_3H3A: begin
				if (hand)
					close_pulse = rise[SW_CLOSE] || rise[SW_CLOSE_B]
						|| key_close || serial_close;
				else if (auto_pos) begin
					close_pulse = auto_close_pulse;
					open_pulse = open_pulse || fall[SW_AUTO_STOP];
				end
				open_pulse = open_pulse || stop_press;
			end
			FCC_HA_3H2A: begin
				if (ha_auto) begin
					is_maint = 1'b1;
					maintained = two_wire_lvl;
				end else
					close_pulse = rise[SW_CLOSE] || rise[SW_CLOSE_B]
						|| key_close || serial_close;
				open_pulse = open_pulse || stop_press;
			end
			default: begin
				open_pulse = 1'b1;
			end
		endcase
	end

	assign permit = lvl[SW_OPEN] && !trip_reg && !alarm_drop;

	// ----------------------------------------------------------------
	// Primary relay
	// ----------------------------------------------------------------
	logic relay_next; // Next relay state
	logic oc_pulse; // Open circuit alarm event
	logic weld_pulse; // Welded contactor event

	always_comb begin
		relay_next = relay_a;
		if (!permit || open_pulse || (is_hoa && off_pos))
			relay_next = 1'b0;
		else if (is_maint)
			relay_next = maintained;
		else if (close_pulse)
			relay_next = 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (!reset_n)
			relay_a <= 1'b0;
		else
			relay_a <= relay_next;
	end

	// Feedback window supervision
	fcc_supervise #(.TICK_DIV(TICK_DIV), .WINDOW_TICKS(WINDOW_TICKS)) u_sv (
		.mclk(mclk),
		.reset_n(reset_n),
		.relay_on(relay_a),
		.feedback(fb_reg),
		.open_circuit_pulse(oc_pulse),
		.welded_pulse(weld_pulse)
	);

	// Alarm holds the relay off until reset; a maintained input would
	// otherwise toggle the contactor forever
	always_ff @(posedge mclk) begin
		if (!reset_n)
			open_circuit_alarm <= 1'b0;
		else if (oc_pulse)
			open_circuit_alarm <= 1'b1;
		else if (key_reset)
			open_circuit_alarm <= 1'b0;
	end
	assign alarm_drop = open_circuit_alarm || oc_pulse;

	always_ff @(posedge mclk) begin
		if (!reset_n)
			welded_alarm <= 1'b0;
		else if (weld_pulse)
			welded_alarm <= 1'b1;
		else if (key_reset && !fb_reg)
			welded_alarm <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Status outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			unavailable <= 1'b1;
			tripped <= 1'b0;
		end else begin
			unavailable <= !lvl[SW_OPEN] || trip_reg;
			tripped <= trip_reg;
		end
	end

endmodule : fcc_control

// >>> tb/fcc_control_properties.sv
// Checker of relay drive, latched trips and feedback alarms
`timescale 1ns/10ps
module fcc_control_checker #(
	parameter int DEB_CYCLES = 4,
	parameter int TICK_DIV = 4,
	parameter int WINDOW_TICKS = 5
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Watched inputs
	input wire logic faceplate_open_latched,
	input wire logic open_perm_in,
	input wire logic contactor_fb_in,
	input wire logic key_open,
	input wire logic key_reset,
	// Watched outputs
	input wire logic relay_a,
	input wire logic unavailable,
	input wire logic tripped,
	input wire logic open_circuit_alarm,
	input wire logic welded_alarm
);
	// ------------------------------------------------------------
	// Helper counters
	// ------------------------------------------------------------
	// Tick rounding allows one tick early, sync adds a few late
	localparam int EARLY = TICK_DIV * (WINDOW_TICKS - 1);
	localparam int LIMIT = TICK_DIV * (WINDOW_TICKS + 1) + 4;
	int on_cnt; // Cycles since relay energised
	int off_cnt; // Cycles since relay dropped
	logic fb_seen; // Feedback came in this closure
	int perm_low_cnt; // Cycles the raw permissive has been low
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Saturating counts keep the int from wrapping
	always_ff @(posedge mclk) begin
		if (!reset_n || !relay_a)
			on_cnt <= 0;
		else if (on_cnt < 1000)
			on_cnt <= on_cnt + 1;
	end
	// Off time, mirror of the above
	always_ff @(posedge mclk) begin
		if (!reset_n || relay_a)
			off_cnt <= 0;
		else if (off_cnt < 1000)
			off_cnt <= off_cnt + 1;
	end
	// Permissive low time, saturating just past sync and debounce
	always_ff @(posedge mclk) begin
		if (!reset_n || open_perm_in)
			perm_low_cnt <= 0;
		else if (perm_low_cnt <= DEB_CYCLES + 3)
			perm_low_cnt <= perm_low_cnt + 1;
	end
	// Remember feedback for the current closure
	always_ff @(posedge mclk) begin
		if (!reset_n || !relay_a)
			fb_seen <= 1'b0;
		else if (contactor_fb_in)
			fb_seen <= 1'b1;
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	chk_perm_blocks: assert property (
		perm_low_cnt > DEB_CYCLES + 3 |-> !relay_a)
		else $error("relay closed without permissive");
	chk_key_trip: assert property (
		key_open && faceplate_open_latched |=> !relay_a ##1 tripped)
		else $error("latched open key did not trip");
	chk_trip_holds: assert property (
		tripped && !key_reset && !$past(key_reset) |=> !$rose(relay_a))
		else $error("relay reclosed while tripped");
	chk_trip_unavail: assert property (
		tripped |-> unavailable)
		else $error("trip not shown as unavailable");
	chk_oc_drops: assert property (
		$rose(open_circuit_alarm) |=> !relay_a)
		else $error("relay held after open circuit alarm");
	chk_oc_bound: assert property (
		relay_a && !fb_seen |-> on_cnt < LIMIT)
		else $error("no feedback yet relay still energised");
	chk_oc_early: assert property (
		$rose(open_circuit_alarm) |-> on_cnt >= EARLY)
		else $error("open circuit alarm too early");
	chk_weld_early: assert property (
		$rose(welded_alarm) |-> off_cnt >= EARLY && !relay_a)
		else $error("welded alarm too early");
	// Main scenarios reached
	cover property ($rose(open_circuit_alarm));
	cover property ($rose(welded_alarm));
	cover property ($rose(tripped));
endmodule : fcc_control_checker

bind fcc_control fcc_control_checker #(
	.DEB_CYCLES(DEB_CYCLES),
	.TICK_DIV(TICK_DIV),
	.WINDOW_TICKS(WINDOW_TICKS)
) u_chk (
	.mclk(mclk),
	.reset_n(reset_n),
	.faceplate_open_latched(faceplate_open_latched),
	.open_perm_in(open_perm_in),
	.contactor_fb_in(contactor_fb_in),
	.key_open(key_open),
	.key_reset(key_reset),
	.relay_a(relay_a),
	.unavailable(unavailable),
	.tripped(tripped),
	.open_circuit_alarm(open_circuit_alarm),
	.welded_alarm(welded_alarm)
);

// >>> tb/fcc_contactor_model.sv
// Behavioural contactor whose auxiliary contact feeds back
`timescale 1ns/10ps
module fcc_contactor_model (
	// Clock
	input wire logic mclk,
	// Coil drive; mode 0 prompt, 1 slow, 2 dead, 3 welded
	input wire logic relay_a,
	input wire logic [1:0] mode,
	// Auxiliary contact, low when open
	output logic fb
);
	logic [11:0] coil_reg = 12'h0; // Coil history, a bit a cycle
	logic stuck_reg = 1'b0; // Welded tips memory
	// Armature travel delay
	always_ff @(posedge mclk) begin
		coil_reg <= {coil_reg[10:0], relay_a};
	end
	// Welded tips stay shut once made
	always_ff @(posedge mclk) begin
		stuck_reg <= (mode == 2'h3) && (stuck_reg || coil_reg[1]);
	end
	// Slow answer still lands inside the window
	always_comb begin
		case (mode)
			2'h0: fb = coil_reg[1];
			2'h1: fb = coil_reg[11];
			2'h2: fb = 1'b0;
			default: fb = stuck_reg;
		endcase
	end
endmodule : fcc_contactor_model

// >>> tb/testbench.sv
// Self-checking bench of the feeder close/open control block
`timescale 1ns/10ps
module testbench;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [2:0] scheme = 3'h0;
	logic fo_lat = 1'b0, po_lat = 1'b0; // Latched open options
	logic [3:0] sel_tw = 4'h1, sel_ap = 4'h0, sel_ac = 4'h0;
	logic perm = 1'b1, cl = 1'b0, clb = 1'b0, stp = 1'b1;
	logic hand = 1'b0, auto = 1'b0, astp = 1'b1;
	logic [9:0] ilk = 10'h0; // Interlock contacts
	logic [5:0] keys = 6'h0; // Proc, ser close, ser open, rst, cls, open
	logic [1:0] mode = 2'h0; // Contactor behaviour
	logic fb, relay, unav, trip, oc, weld;
	logic [9:0] q[$]; // Notes of {mask, expected}
	logic [9:0] e;
	logic [31:0] rnd;
	int bad_count = 0, cmp_count = 0;
	event chk_ev;
	always #50 mclk = ~mclk;
	// ------------------------------------------------------------
	// Design and contactor
	// ------------------------------------------------------------
	fcc_control #(.DEB_CYCLES(4), .TICK_DIV(4), .WINDOW_TICKS(5)) uut (
		.mclk(mclk), .reset_n(reset_n), .scheme(scheme),
		.faceplate_open_latched(fo_lat), .process_open_latched(po_lat),
		.sel_two_wire(sel_tw), .sel_auto_perm(sel_ap),
		.sel_auto_close(sel_ac), .open_perm_in(perm), .close_in(cl),
		.close_b_in(clb), .stop_pb_in(stp), .hand_in(hand),
		.auto_in(auto), .auto_stop_in(astp), .interlock_in(ilk),
		.contactor_fb_in(fb), .key_open(keys[0]), .key_close(keys[1]),
		.key_reset(keys[2]), .serial_open(keys[3]),
		.serial_close(keys[4]), .process_open(keys[5]),
		.relay_a(relay), .unavailable(unav), .tripped(trip),
		.open_circuit_alarm(oc), .welded_alarm(weld));
	fcc_contactor_model u_con (.mclk(mclk), .relay_a(relay),
		.mode(mode), .fb(fb));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	// One-cycle key pulse, then room for trip flags
	task automatic kp(input logic [5:0] k);
		keys = k;
		tick(1);
		keys = 6'h0;
		tick(3);
	endtask : kp
	// Note an expectation for the watcher
	task automatic exp(input logic [4:0] m, input logic [4:0] v);
		q.push_back({m, v & m});
		-> chk_ev;
	endtask : exp
	// Let debounce settle, then note
	task automatic see(input logic [4:0] m, input logic [4:0] v);
		tick(12);
		exp(m, v);
	endtask : see
	// Momentary contact, held past debounce
	task automatic press(input int w);
		case (w)
			0: cl = 1'b1;
			1: clb = 1'b1;
			2: stp = 1'b0;
			3: astp = 1'b0;
			default: ilk[2] = 1'b1;
		endcase
		tick(8);
		{cl, clb, stp, astp, ilk[2]} = 5'h06;
		tick(12);
	endtask : press
	task automatic check(input logic [4:0] seen, input logic [4:0] want);
		cmp_count++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h",
				$time, seen, want);
		end
	endtask : check
	task automatic report_and_stop();
		if (bad_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	// Bounded wait for one of the alarms
	task automatic wait_alarm(input logic w);
		int i;
		for (i = 0; i < 60 && (w ? weld : oc) !== 1'b1; i++)
			tick(1);
		if (i == 60) begin
			bad_count++;
			report_and_stop();
		end
	endtask : wait_alarm
	// Watcher: compares every queued note, oldest first, with the outputs
	always @(chk_ev) begin
		while (q.size() > 0) begin
			e = q.pop_front();
			check({relay, trip, unav, oc, weld} & e[9:5], e[4:0]);
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rnd = $urandom(32'h22e4);
		tick(4);
		reset_n = 1'b1;
		tick(12);
		// Two-wire on every interlock, random noise on the rest
		for (int k = 1; k <= 10; k++) begin
			mode = k[0] ? 2'h1 : 2'h0;
			sel_tw = 4'(k);
			rnd = $urandom();
			ilk = rnd[9:0] | (10'h1 << (k - 1));
			see(5'h10, 5'h10);
			ilk = ilk & ~(10'h1 << (k - 1));
			see(5'h10, 5'h00);
			ilk = 10'h0;
		end
		sel_tw = 4'h1;
		mode = 2'h0;
		// Short glitch is filtered
		ilk = 10'h1;
		tick(2);
		ilk = 10'h0;
		see(5'h10, 5'h00);
		// Permissive low refuses close
		perm = 1'b0;
		ilk = 10'h1;
		see(5'h14, 5'h04);
		perm = 1'b1;
		see(5'h14, 5'h10);
		// Latched trips and reclose on reset
		fo_lat = 1'b1;
		po_lat = 1'b1;
		kp(6'h01);
		exp(5'h1c, 5'h0c);
		kp(6'h02);
		exp(5'h10, 5'h00);
		kp(6'h04);
		exp(5'h1c, 5'h10);
		kp(6'h20);
		exp(5'h1c, 5'h0c);
		ilk = 10'h0;
		tick(12);
		kp(6'h04);
		exp(5'h1c, 5'h00);
		// Dead contactor raises the open circuit alarm
		mode = 2'h2;
		ilk = 10'h1;
		wait_alarm(1'b0);
		tick(2);
		exp(5'h12, 5'h02);
		ilk = 10'h0;
		mode = 2'h0;
		tick(12);
		kp(6'h04);
		exp(5'h12, 5'h00);
		// Welded tips after drop
		mode = 2'h3;
		ilk = 10'h1;
		tick(12);
		ilk = 10'h0;
		wait_alarm(1'b1);
		exp(5'h11, 5'h01);
		mode = 2'h0;
		tick(4);
		kp(6'h04);
		exp(5'h01, 5'h00);
		// Hand/off/auto, two-wire hand
		scheme = 3'h1;
		hand = 1'b1;
		see(5'h10, 5'h10);
		hand = 1'b0;
		see(5'h10, 5'h00);
		auto = 1'b1;
		ilk = 10'h1;
		see(5'h10, 5'h10);
		auto = 1'b0;
		see(5'h10, 5'h00);
		// Three-wire hand, two-wire auto
		scheme = 3'h2;
		hand = 1'b1;
		ilk = 10'h0;
		tick(12);
		press(0);
		exp(5'h10, 5'h10);
		press(2);
		exp(5'h10, 5'h00);
		press(0);
		kp(6'h08);
		exp(5'h10, 5'h00);
		hand = 1'b0;
		auto = 1'b1;
		ilk = 10'h1;
		see(5'h10, 5'h10);
		press(2);
		exp(5'h10, 5'h10);
		// Three-wire both
		scheme = 3'h3;
		sel_ac = 4'h3;
		ilk = 10'h0;
		tick(12);
		press(3);
		exp(5'h10, 5'h00);
		press(4);
		exp(5'h10, 5'h10);
		press(2);
		exp(5'h10, 5'h00);
		// Hand/auto, auto mode by permissive interlock
		scheme = 3'h4;
		auto = 1'b0;
		sel_ap = 4'h2;
		tick(12);
		press(0);
		exp(5'h10, 5'h10);
		press(2);
		exp(5'h1c, 5'h0c);
		kp(6'h04);
		exp(5'h1c, 5'h00);
		ilk = 10'h2;
		tick(12);
		press(0);
		press(1);
		kp(6'h02);
		kp(6'h10);
		exp(5'h10, 5'h00);
		ilk = 10'h3;
		see(5'h10, 5'h10);
		press(2);
		exp(5'h18, 5'h08);
		report_and_stop();
	end
endmodule : testbench
